// ### hw/driver_protection_clock_supervisor.sv
// Protection, reset and clock supervision for a stepper motor driver.
`timescale 1ns/1ps

// How it works
// - Warning flag follows the 100 C comparator.
// - At 150 C disable bridges, set shutdown.
// - Compensated slope gains one step when warm.
// - Codes 1 and 2 compensated; 0,3 fixed.
// - Undervoltage resets logic, switches off bridges.
// - Undervoltage clears configuration to zero.
// - Undervoltage gives zero responses, no passthrough.
// - Current scale reads zero after undervoltage.
// - Power-up holds serial unit, ignores accesses.
// - Runs from oscillator, accepts external clock.
// - First clock pin high selects external, permanently.
// - No fallback to oscillator once switched.
// - Short protection works without a clock.
// - Standstill flag after fixed clocks idle.
// - Disable input or zero off-time stops bridges.
module driver_protection_clock_supervisor #(
	parameter int STANDSTILL_COUNT = supervisor_pkg::STANDSTILL_CLOCKS
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [supervisor_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [supervisor_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [supervisor_pkg::DATA_W-1:0] reg_rdata,
	input wire logic die_over_warn,
	input wire logic die_over_shut,
	input wire logic uv_logic_supply,
	input wire logic uv_motor_supply,
	input wire logic output_disable_input,
	input wire logic step_pulse,
	input wire logic clk_pin_level,
	input wire logic [1:0] short_detect,
	input wire logic sdi,
	input wire logic shift_sdo,
	output logic shift_sdi,
	output logic sdo,
	output logic serial_unit_reset,
	output logic bridge_enable,
	output logic [1:0] short_shutoff,
	output logic [supervisor_pkg::SLOPE_W-1:0] high_side_drive_code,
	output logic osc_enable,
	output logic ext_clk_select,
	output logic overtemp_warning_flag,
	output logic overtemp_shutdown_flag,
	output logic standstill_flag,
	output logic [supervisor_pkg::SCALE_W-1:0] actual_current_scale_readback,
	output logic irq
);

	// True when a bus address selects the given register.
	function automatic logic reg_hit(
		input logic [supervisor_pkg::ADDR_W-1:0] addr,
		input logic [supervisor_pkg::ADDR_W-1:0] offset
	);
		return addr == offset;
	endfunction

	// Either supply low counts as undervoltage.
	logic uv_any;

	// Serial unit held while starting up or in undervoltage.
	logic hold_ff;

	// Bus accesses only count when the serial unit runs.
	logic access_ok;

	// Configuration register and its next value.
	supervisor_pkg::cfg_t cfg_ff;
	supervisor_pkg::cfg_t nxt_cfg;

	// Temperature flags.
	logic warn_ff;
	logic shut_ff;

	// Previous values for edge events.
	logic warn_q_ff;
	logic shut_q_ff;
	logic still_q_ff;
	logic uv_q_ff;

	// Standstill level from the timer.
	logic still;

	// Clock source state.
	supervisor_pkg::clk_src_t clk_src_ff;
	supervisor_pkg::clk_src_t nxt_clk_src;

	// Interrupt status, mask and event pulses.
	logic [supervisor_pkg::EV_N-1:0] int_stat_ff;
	logic [supervisor_pkg::EV_N-1:0] int_mask_ff;
	logic [supervisor_pkg::EV_N-1:0] events;

	// Effective high-side drive code.
	logic [supervisor_pkg::SLOPE_W-1:0] nxt_drive;
	logic [supervisor_pkg::SLOPE_W-1:0] drive_ff;

	// Bridge permission and read data.
	logic bridge_ff;
	logic [supervisor_pkg::DATA_W-1:0] rdata_ff;
	logic [supervisor_pkg::DATA_W-1:0] nxt_rdata;
	supervisor_pkg::resp_t resp;

	// Supplies are sampled as synchronous levels.
	assign uv_any = uv_logic_supply | uv_motor_supply;

	// The serial unit stays in reset during power-up and undervoltage.
	// It is a flop, so the first access counts one edge after release.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			hold_ff <= 1'b1;
		end else begin
			hold_ff <= uv_any;
		end
	end

	// Accesses during the hold are dropped, not delayed.
	assign access_ok = !hold_ff && !uv_any;
	assign serial_unit_reset = hold_ff;

	// Next configuration: a write to CONFIG replaces the whole word.
	always_comb begin
		nxt_cfg = cfg_ff;
		if (reg_wr && access_ok) begin
			if (reg_hit(reg_addr, supervisor_pkg::OFF_CONFIG)) begin
				nxt_cfg = supervisor_pkg::cfg_t'(
					reg_wdata[$bits(supervisor_pkg::cfg_t)-1:0]);
			end
		end
	end

	// Undervoltage wipes the configuration, so the host sees scale 0.
	always_ff @(posedge ref_clk) begin
		if (!rst_n || uv_any) begin
			cfg_ff <= supervisor_pkg::CFG_RESET;
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end

	// Warning follows the comparator level while above threshold.
	always_ff @(posedge ref_clk) begin
		if (!rst_n || uv_any) begin
			warn_ff <= 1'b0;
		end else begin
			warn_ff <= die_over_warn;
		end
	end

	// Shutdown latches at the high threshold and is released only
	// once the die is below the warning level too. This hysteresis
	// stops the bridges from toggling around the shutdown point.
	always_ff @(posedge ref_clk) begin
		if (!rst_n || uv_any) begin
			shut_ff <= 1'b0;
		end else if (die_over_shut) begin
			shut_ff <= 1'b1;
		end else if (!die_over_warn) begin
			shut_ff <= 1'b0;
		end
	end

	// Edge history for interrupt events.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			warn_q_ff <= 1'b0;
			shut_q_ff <= 1'b0;
			still_q_ff <= 1'b0;
			uv_q_ff <= 1'b0;
		end else begin
			warn_q_ff <= warn_ff;
			shut_q_ff <= shut_ff;
			still_q_ff <= still;
			uv_q_ff <= uv_any;
		end
	end

	// Rising edges of each condition are the events.
	assign events[supervisor_pkg::EV_WARN] = warn_ff && !warn_q_ff;
	assign events[supervisor_pkg::EV_SHUT] = shut_ff && !shut_q_ff;
	assign events[supervisor_pkg::EV_STANDSTILL] = still && !still_q_ff;
	assign events[supervisor_pkg::EV_UNDERVOLT] = uv_any && !uv_q_ff;

	// Temperature compensation: the two compensated codes step up by
	// one while warm; the fixed codes ignore temperature.
	always_comb begin
		nxt_drive = cfg_ff.high_side_slope_setting;
		case (cfg_ff.high_side_slope_setting)
			supervisor_pkg::SLOPE_MIN_TC: begin
				if (warn_ff) begin
					nxt_drive = supervisor_pkg::SLOPE_MED_TC;
				end
			end
			supervisor_pkg::SLOPE_MED_TC: begin
				if (warn_ff) begin
					nxt_drive = supervisor_pkg::SLOPE_MAX;
				end
			end
			default: begin
				nxt_drive = cfg_ff.high_side_slope_setting;
			end
		endcase
	end

	// Registered so the gate driver code never glitches.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			drive_ff <= supervisor_pkg::SLOPE_MIN;
		end else begin
			drive_ff <= nxt_drive;
		end
	end

	// Bridges run only when nothing forbids them. A zero off-time and
	// the disable pin act alike, whatever else is configured.
	always_ff @(posedge ref_clk) begin
		if (!rst_n || uv_any) begin
			bridge_ff <= 1'b0;
		end else begin
			bridge_ff <= !shut_ff &&
				!output_disable_input &&
				(cfg_ff.chopper_off_time != supervisor_pkg::CHOP_OFF_ZERO) &&
				(short_shutoff == 2'h0);
		end
	end

	// The bridge gate also takes the pin and undervoltage directly,
	// so power stages drop without waiting for a clock edge.
	assign bridge_enable = bridge_ff && !output_disable_input && !uv_any;

	// Short protection is pure gating; it needs no running clock.
	// The disable bit is held state and keeps its value unclocked.
	assign short_shutoff = short_detect & {2{!cfg_ff.s2g_disable}};

	// Clock source: the first high on the clock pin moves to the
	// external clock for good. There is no path back, so if that
	// clock stops the device simply stops; the host must switch the
	// bridges off first.
	always_comb begin
		nxt_clk_src = clk_src_ff;
		case (clk_src_ff)
			supervisor_pkg::CLK_OSC: begin
				if (clk_pin_level) begin
					nxt_clk_src = supervisor_pkg::CLK_EXT;
				end
			end
			supervisor_pkg::CLK_EXT: begin
				nxt_clk_src = supervisor_pkg::CLK_EXT;
			end
			default: begin
				nxt_clk_src = supervisor_pkg::CLK_OSC;
			end
		endcase
	end

	// Only a full reset returns to the oscillator; undervoltage
	// does not, since the pin choice is a board property.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			clk_src_ff <= supervisor_pkg::CLK_OSC;
		end else begin
			clk_src_ff <= nxt_clk_src;
		end
	end

	assign osc_enable = (clk_src_ff == supervisor_pkg::CLK_OSC);
	assign ext_clk_select = (clk_src_ff == supervisor_pkg::CLK_EXT);

	// Standstill timer; undervoltage restarts it.
	standstill_timer #(
		.COUNT(STANDSTILL_COUNT)
	) u_standstill (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clear(uv_any),
		.step_pulse(step_pulse),
		.standstill(still)
	);

	// Interrupt status: each bit is sticky, one clears it, and a new
	// event in the clearing cycle wins. These survive undervoltage on
	// purpose, so software can still learn that one happened.
	genvar gi;
	generate
		for (gi = 0; gi < supervisor_pkg::EV_N; gi++) begin : g_int
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					int_stat_ff[gi] <= supervisor_pkg::EV_RESET[gi];
				end else if (events[gi]) begin
					int_stat_ff[gi] <= 1'b1;
				end else if (reg_wr && access_ok &&
					reg_hit(reg_addr, supervisor_pkg::OFF_INT_STATUS) &&
					reg_wdata[gi]) begin
					int_stat_ff[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Mask register: a one lets that event drive the interrupt.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			int_mask_ff <= supervisor_pkg::EV_RESET;
		end else if (reg_wr && access_ok &&
			reg_hit(reg_addr, supervisor_pkg::OFF_INT_MASK)) begin
			int_mask_ff <= reg_wdata[supervisor_pkg::EV_N-1:0];
		end
	end

	// Level interrupt while any unmasked status bit is set.
	assign irq = |(int_stat_ff & int_mask_ff);

	// Response word as the host sees it.
	always_comb begin
		resp.ext_clk_select = ext_clk_select;
		resp.standstill_flag = still;
		resp.overtemp_shutdown_flag = shut_ff;
		resp.overtemp_warning_flag = warn_ff;
		resp.actual_current_scale_readback = cfg_ff.current_scale;
	end

	// Read decode. Unmapped addresses read as zero, and so does every
	// read while the serial unit is held.
	always_comb begin
		nxt_rdata = '0;
		if (reg_rd && access_ok) begin
			if (reg_hit(reg_addr, supervisor_pkg::OFF_CONFIG)) begin
				nxt_rdata[$bits(supervisor_pkg::cfg_t)-1:0] = cfg_ff;
			end else if (reg_hit(reg_addr, supervisor_pkg::OFF_RESPONSE)) begin
				nxt_rdata[$bits(supervisor_pkg::resp_t)-1:0] = resp;
			end else if (reg_hit(reg_addr, supervisor_pkg::OFF_INT_STATUS)) begin
				nxt_rdata[supervisor_pkg::EV_N-1:0] = int_stat_ff;
			end else if (reg_hit(reg_addr, supervisor_pkg::OFF_INT_MASK)) begin
				nxt_rdata[supervisor_pkg::EV_N-1:0] = int_mask_ff;
			end else if (reg_hit(reg_addr, supervisor_pkg::OFF_DRIVE)) begin
				nxt_rdata[supervisor_pkg::SLOPE_W-1:0] = drive_ff;
			end else begin
				nxt_rdata = '0;
			end
		end
	end

	// Read data stand in the cycle after the strobe only.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rdata_ff <= '0;
		end else if (uv_any) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// Serial path: during the hold nothing enters or leaves the shift
	// register, so a probing host sees only zeros.
	assign shift_sdi = sdi && !hold_ff && !uv_any;
	assign sdo = shift_sdo && !hold_ff && !uv_any;

	// Outputs.
	assign reg_rdata = rdata_ff;
	assign high_side_drive_code = drive_ff;
	assign overtemp_warning_flag = warn_ff;
	assign overtemp_shutdown_flag = shut_ff;
	assign standstill_flag = still;
	assign actual_current_scale_readback = cfg_ff.current_scale;

endmodule

// ### include/supervisor_pkg.sv
// Shared constants and types for the driver protection and clock supervisor.
package supervisor_pkg;

	// Register bus widths.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets.
	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_RESPONSE = 8'h04;
	localparam logic [7:0] OFF_INT_STATUS = 8'h08;
	localparam logic [7:0] OFF_INT_MASK = 8'h0c;
	localparam logic [7:0] OFF_DRIVE = 8'h10;

	// Widths of the configuration fields.
	localparam int SCALE_W = 5;
	localparam int CHOP_OFF_W = 4;
	localparam int SLOPE_W = 2;

	// High-side slope codes; the middle two follow temperature.
	localparam logic [1:0] SLOPE_MIN = 2'h0;
	localparam logic [1:0] SLOPE_MIN_TC = 2'h1;
	localparam logic [1:0] SLOPE_MED_TC = 2'h2;
	localparam logic [1:0] SLOPE_MAX = 2'h3;

	// Chopper off-time value that switches the bridges off.
	localparam logic [3:0] CHOP_OFF_ZERO = 4'h0;

	// Configuration word, held in the low bits of CONFIG.
	typedef struct packed {
		logic [SCALE_W-1:0] current_scale;
		logic s2g_disable;
		logic [CHOP_OFF_W-1:0] chopper_off_time;
		logic [SLOPE_W-1:0] high_side_slope_setting;
	} cfg_t;

	// Everything in the configuration word is zero after reset.
	localparam cfg_t CFG_RESET = '0;

	// Status word returned at RESPONSE.
	typedef struct packed {
		logic ext_clk_select;
		logic standstill_flag;
		logic overtemp_shutdown_flag;
		logic overtemp_warning_flag;
		logic [SCALE_W-1:0] actual_current_scale_readback;
	} resp_t;

	// Interrupt event bits, same layout in status and mask.
	localparam int EV_N = 4;
	localparam int EV_WARN = 0;
	localparam int EV_SHUT = 1;
	localparam int EV_STANDSTILL = 2;
	localparam int EV_UNDERVOLT = 3;
	localparam logic [EV_N-1:0] EV_RESET = 4'h0;

	// Clock source, one-hot.
	typedef enum logic [1:0] {
		CLK_OSC = 2'b01,
		CLK_EXT = 2'b10
	} clk_src_t;

	// Standstill delay after the last step, in system clocks.
	localparam int STANDSTILL_CLOCKS = 32'h0010_0000;

endpackage

// ### hw/standstill_timer.sv
// Standstill timer: counts clocks since the last step pulse.
`timescale 1ns/1ps

module standstill_timer #(
	parameter int COUNT = supervisor_pkg::STANDSTILL_CLOCKS
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic step_pulse,
	output logic standstill
);

	// Just wide enough that the terminal value COUNT fits.
	localparam int CNT_W = $clog2(COUNT + 1);
	localparam logic [CNT_W-1:0] CNT_END = CNT_W'(COUNT);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	logic [CNT_W-1:0] cnt_ff; // Clocks since the last step.
	logic [CNT_W-1:0] nxt_cnt;
	logic done_ff; // Standstill reached.

	// Saturate at the end value so the flag cannot wrap back off.
	always_comb begin
		if (cnt_ff == CNT_END) begin
			nxt_cnt = cnt_ff;
		end else begin
			nxt_cnt = cnt_ff + CNT_ONE;
		end
	end

	// A step restarts the count; clear also holds it at zero.
	always_ff @(posedge ref_clk) begin
		if (!rst_n || clear || step_pulse) begin
			cnt_ff <= '0;
			done_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			done_ff <= (nxt_cnt == CNT_END);
		end
	end

	assign standstill = done_ff;

endmodule

// ### verification/supervisor_checker.sv
// Concurrent assertions for the supervisor, bound to its top module.
`timescale 1ns/1ps
module supervisor_checker #(
	parameter int STANDSTILL_COUNT = supervisor_pkg::STANDSTILL_CLOCKS
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic reg_rd,
	input wire logic [supervisor_pkg::DATA_W-1:0] reg_rdata,
	input wire logic die_over_warn,
	input wire logic uv_logic_supply,
	input wire logic uv_motor_supply,
	input wire logic output_disable_input,
	input wire logic step_pulse,
	input wire logic clk_pin_level,
	input wire logic [1:0] short_detect,
	input wire logic shift_sdi,
	input wire logic sdo,
	input wire logic serial_unit_reset,
	input wire logic bridge_enable,
	input wire logic [1:0] short_shutoff,
	input wire logic osc_enable,
	input wire logic ext_clk_select,
	input wire logic overtemp_warning_flag,
	input wire logic overtemp_shutdown_flag,
	input wire logic standstill_flag,
	input wire logic [supervisor_pkg::SCALE_W-1:0] actual_current_scale_readback
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Either supply low counts as undervoltage.
	logic uv;
	assign uv = uv_logic_supply | uv_motor_supply;
	// Clocks since the standstill count last restarted.
	logic [31:0] idle_ff;
	// Restarts match the timer, so the flag can be timed exactly.
	always_ff @(posedge ref_clk) begin
		if (!rst_n || uv || step_pulse) begin
			idle_ff <= '0;
		end else begin
			idle_ff <= idle_ff + 32'h1;
		end
	end
	a_warn_follow: assert property (!uv |=>
		overtemp_warning_flag == $past(die_over_warn))
		else $error("warning flag does not follow comparator");
	a_shut_bridge: assert property (overtemp_shutdown_flag [*2]
		|-> !bridge_enable) else $error("bridge on during shutdown");
	a_uv_bridge: assert property (uv |-> !bridge_enable)
		else $error("bridge on during undervoltage");
	a_uv_serial: assert property (uv |-> !shift_sdi && !sdo)
		else $error("serial path open during undervoltage");
	a_uv_clear: assert property (uv |=> serial_unit_reset &&
		actual_current_scale_readback == '0 && !overtemp_warning_flag)
		else $error("undervoltage did not clear state");
	a_disable_bridge: assert property (output_disable_input
		|-> !bridge_enable) else $error("bridge on while disabled");
	a_ext_sticky: assert property ((clk_pin_level || ext_clk_select)
		|=> ext_clk_select && !osc_enable)
		else $error("clock source not held on external");
	a_short_live: assert property ((short_shutoff & ~short_detect)
		== 2'b00) else $error("short shutoff without a short");
	a_stand_time: assert property (standstill_flag
		|-> idle_ff >= STANDSTILL_COUNT)
		else $error("standstill flag too early");
	a_step_clear: assert property (step_pulse |=> !standstill_flag)
		else $error("standstill flag kept after step");
	a_read_idle: assert property (!reg_rd |=> reg_rdata == '0)
		else $error("read data outside its cycle");
	a_hold_read: assert property (serial_unit_reset && reg_rd
		|=> reg_rdata == '0) else $error("read answered during hold");
	a_stand_due: assert property (idle_ff == STANDSTILL_COUNT
		|-> standstill_flag) else $error("standstill flag too late");
	a_short_bridge: assert property (short_shutoff != 2'b00
		|=> !bridge_enable) else $error("bridge on after short");
	cover property (overtemp_shutdown_flag && !bridge_enable);
	cover property ($rose(ext_clk_select));
	cover property ($rose(standstill_flag));
	cover property (uv ##1 serial_unit_reset);
endmodule

bind driver_protection_clock_supervisor supervisor_checker #(
	.STANDSTILL_COUNT(STANDSTILL_COUNT)
) chk (
	.ref_clk, .rst_n, .reg_rd, .reg_rdata, .die_over_warn,
	.uv_logic_supply, .uv_motor_supply, .output_disable_input,
	.step_pulse, .clk_pin_level, .short_detect, .shift_sdi, .sdo,
	.serial_unit_reset, .bridge_enable, .short_shutoff, .osc_enable,
	.ext_clk_select, .overtemp_warning_flag, .overtemp_shutdown_flag,
	.standstill_flag, .actual_current_scale_readback
);

// ### verification/host_model.sv
// Host side model: clock pin, serial input and bridge disable.
`timescale 1ns/1ps
module host_model (
	input wire logic ref_clk,
	input wire logic ext_on,
	input wire logic park,
	output logic clk_pin_level,
	output logic sdi,
	output logic output_disable_input
);
	logic ph = 1'b0; // External clock phase.
	logic sd = 1'b0; // Serial data pattern.
	// The pin is held low unless an external clock is wanted.
	always @(posedge ref_clk) begin
		ph <= ext_on ? ~ph : 1'b0;
		sd <= ~sd;
	end
	assign clk_pin_level = ph;
	// Serial data changes every cycle so a stuck path shows.
	assign sdi = sd;
	// The bench raises park before it stops the clock.
	assign output_disable_input = park;
endmodule

// ### verification/driver_protection_clock_supervisor_tb.sv
// Self-checking bench for the protection and clock supervisor.
`timescale 1ns/1ps
module driver_protection_clock_supervisor_tb;
	localparam int N = 16; // Short standstill count.
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic die_over_warn = 1'b0;
	logic die_over_shut = 1'b0;
	logic uv_logic_supply = 1'b0;
	logic uv_motor_supply = 1'b0;
	logic step_pulse = 1'b0;
	logic [1:0] short_detect = 2'h0;
	logic shift_sdo = 1'b0;
	logic ext_on = 1'b0;
	logic park = 1'b0;
	logic [31:0] reg_rdata, d;
	logic output_disable_input, clk_pin_level, sdi, shift_sdi, sdo, irq;
	logic serial_unit_reset, bridge_enable, osc_enable, ext_clk_select;
	logic overtemp_warning_flag, overtemp_shutdown_flag, standstill_flag;
	logic [1:0] short_shutoff, high_side_drive_code;
	logic [4:0] actual_current_scale_readback;
	int n_errors = 0;
	int samples_checked = 0;
	// Rows: slope code, warning, expected drive code.
	logic [4:0] rows [8] = '{5'h00, 5'h09, 5'h12, 5'h1b,
		5'h04, 5'h0e, 5'h17, 5'h1f};
	driver_protection_clock_supervisor #(.STANDSTILL_COUNT(N)) dut (
		.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .die_over_warn, .die_over_shut, .uv_logic_supply,
		.uv_motor_supply, .output_disable_input, .step_pulse,
		.clk_pin_level, .short_detect, .sdi, .shift_sdo, .shift_sdi, .sdo,
		.serial_unit_reset, .bridge_enable, .short_shutoff,
		.high_side_drive_code, .osc_enable, .ext_clk_select,
		.overtemp_warning_flag, .overtemp_shutdown_flag, .standstill_flag,
		.actual_current_scale_readback, .irq);
	host_model host (.ref_clk, .ext_on, .park, .clk_pin_level, .sdi,
		.output_disable_input);
	// One-bit stand-in for the serial shift register.
	always @(posedge ref_clk) shift_sdo <= shift_sdi;
	initial forever #5 ref_clk = ~ref_clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// A gap cycle follows each strobe, so no signal is driven twice.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// The whole run takes well under this span.
	initial begin
		#100000;
		n_errors++;
		$display("BAD %0t timeout", $time);
		end_sim();
	end
	initial begin
		tick(4);
		rst_n <= 1'b1;
		tick(1);
		#1 chk(osc_enable, 1);
		chk(bridge_enable, 0);
		rd(8'h04, d);
		chk(d, 0);
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk) die_over_warn <= rows[i][2];
			wr(8'h00, 32'h884 | rows[i][4:3]);
			tick(2);
			rd(8'h10, d);
			chk(d, rows[i][1:0]);
			chk(high_side_drive_code, rows[i][1:0]);
			chk(overtemp_warning_flag, rows[i][2]);
		end
		rd(8'h20, d);
		chk(d, 0);
		#1 chk(bridge_enable, 1);
		@(posedge ref_clk) die_over_shut <= 1'b1;
		tick(3);
		#1 chk(bridge_enable, 0);
		chk(overtemp_shutdown_flag, 1);
		rd(8'h04, d);
		chk(d[6:5], 2'b11);
		// Still above the warning level, so shutdown must hold.
		@(posedge ref_clk) die_over_shut <= 1'b0;
		tick(2);
		#1 chk(overtemp_shutdown_flag, 1);
		@(posedge ref_clk) die_over_warn <= 1'b0;
		tick(3);
		#1 chk(bridge_enable, 1);
		@(posedge ref_clk) short_detect <= 2'b10;
		#1 chk(short_shutoff, 2'b10);
		wr(8'h00, 32'h8c5);
		chk(short_shutoff, 2'b00);
		@(posedge ref_clk) short_detect <= 2'b00;
		#1 chk(irq, 0);
		rd(8'h08, d);
		chk(d[1:0], 2'b11);
		wr(8'h0c, 32'h2);
		chk(irq, 1);
		rd(8'h0c, d);
		chk(d, 32'h2);
		wr(8'h08, 32'h7);
		chk(irq, 0);
		@(posedge ref_clk) park <= 1'b1;
		#1 chk(bridge_enable, 0);
		@(posedge ref_clk) park <= 1'b0;
		wr(8'h00, 32'h881);
		tick(1);
		#1 chk(bridge_enable, 0);
		@(posedge ref_clk) step_pulse <= 1'b1;
		@(posedge ref_clk) step_pulse <= 1'b0;
		tick(N - 1);
		#1 chk(standstill_flag, 0);
		tick(1);
		#1 chk(standstill_flag, 1);
		@(posedge ref_clk) ext_on <= 1'b1;
		tick(3);
		#1 chk({ext_clk_select, osc_enable}, 2'b10);
		@(posedge ref_clk) park <= 1'b1;
		@(posedge ref_clk) ext_on <= 1'b0;
		tick(4);
		#1 chk({ext_clk_select, osc_enable}, 2'b10);
		@(posedge ref_clk) park <= 1'b0;
		#1 chk({shift_sdi, sdo}, {sdi, shift_sdo});
		// Each supply alone must act as undervoltage.
		for (int i = 0; i < 2; i++) begin
			wr(8'h00, 32'h885);
			@(posedge ref_clk) {uv_logic_supply, uv_motor_supply} <= 2'h1 << i;
			#1 chk(bridge_enable, 0);
			chk({shift_sdi, sdo}, 0);
			rd(8'h04, d);
			chk(d, 0);
			chk(serial_unit_reset, 1);
			@(posedge ref_clk) {uv_logic_supply, uv_motor_supply} <= 2'h0;
			tick(2);
			rd(8'h00, d);
			chk(d, 0);
			rd(8'h04, d);
			chk(d[4:0], 0);
			// Zero scale tells the host to set the device up again.
			if (d[4:0] == 5'h00) begin
				wr(8'h00, 32'h885);
			end
		end
		rd(8'h08, d);
		chk(d[3], 1'b1);
		// Mid-run reset: a write in the first cycle after it is dropped.
		@(posedge ref_clk) rst_n <= 1'b0;
		tick(3);
		rst_n <= 1'b1;
		reg_addr <= 8'h00;
		reg_wdata <= 32'h885;
		reg_wr <= 1'b1;
		tick(1);
		reg_wr <= 1'b0;
		#1 chk({ext_clk_select, osc_enable}, 2'b01);
		rd(8'h00, d);
		chk(d, 0);
		end_sim();
	end
endmodule
